//--- dps_consts.svh
// constants of the dual position motion sequencer
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_MODE_HALF      2'h0
`define DPS_MODE_QUARTER   2'h1
`define DPS_MODE_EIGHTH    2'h2
`define DPS_MODE_SIXTEENTH 2'h3
`define DPS_NARROW_MSB     4'hC
`define DPS_SAFE_OFF       11'h400
`define DPS_SAFE_PAD       5'h00
`define DPS_POS_ZERO       16'h0000
`define DPS_BUF_DEPTH      4
`define DPS_BUF_MIN        2
`define DPS_BUF_MAX        16
`endif

//--- dps_pkg.sv
// types of the dual position motion sequencer
package dps_pkg;

    typedef enum logic [3:0] {
        DPS_OP_NOP        = 4'h0,
        DPS_OP_MOVE       = 4'h1,
        DPS_OP_MOVE_SHORT = 4'h2,
        DPS_OP_GO_SAFE    = 4'h3,
        DPS_OP_HALT_NOW   = 4'h4,
        DPS_OP_HALT_DECEL = 4'h5,
        DPS_OP_ZERO_POS   = 4'h6,
        DPS_OP_DUAL       = 4'h7,
        DPS_OP_STATUS1    = 4'h8,
        DPS_OP_STATUS2    = 4'h9,
        DPS_OP_PARAM      = 4'hA,
        DPS_OP_RUN        = 4'hB
    } dps_op_t;

    typedef struct packed {
        dps_op_t     op;
        logic [15:0] pos;
        logic [15:0] second_leg_offset;
        logic [3:0]  vmin;
        logic [3:0]  vmax;
    } dps_cmd_t;

    typedef struct packed {
        logic [15:0] target;
        logic [3:0]  vmin;
        logic [3:0]  vmax;
        logic        ramp;
        logic        relative;
    } dps_move_t;

    typedef struct packed {
        logic        is_safe;
        logic [15:0] pos;
    } dps_buf_t;

    typedef enum logic [2:0] {
        DPS_IDLE  = 3'h0,
        DPS_LEG1  = 3'h1,
        DPS_LEG2  = 3'h2,
        DPS_SAFE  = 3'h3,
        DPS_DRAIN = 3'h4
    } dps_state_t;

endpackage

//--- dps_short_dir.sv
// shortest path direction on the circular position space
`timescale 1ns/100ps
`default_nettype none
`include "dps_consts.svh"
module dps_short_dir
(
    input  wire logic [15:0] target,
    input  wire logic [15:0] actual,
    input  wire logic [1:0]  step_mode,
    output logic             dir_pos,
    output logic             at_target
);
    logic [15:0] diff;
    logic [15:0] in_range;
    logic [3:0]  sign_idx;

    // difference wraps at the mode width
    assign diff     = target - actual; // RL14
    assign sign_idx = `DPS_NARROW_MSB + {2'h0, step_mode};

    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_bit
            assign in_range[i] = (4'(i) <= sign_idx);
        end
    endgenerate

    assign at_target = ~|(diff & in_range);
    assign dir_pos   = ~diff[sign_idx] & ~at_target; // RL15 RL23
endmodule
`default_nettype wire

//--- dps_sequencer.sv
// dual positioning command sequencer with position buffer
//
// Summary of operation
// (RL1) dual first leg: command velocities, RAM acceleration, to first leg target.
// (RL2) second leg: relative move to leg sum at start velocity, no ramp.
// (RL3) after second leg clear actual position, keep target position.
// (RL4) with safe position enabled, move there after the dual sequence.
// (RL5) set referenced flag when the dual sequence completes.
// (RL6) only immediate halt or shutdown interrupts a dual sequence.
// (RL7) master should not send dual command while moving.
// (RL8) dual start loads target with safe position or zero.
// (RL9) move and go safe commands during dual are buffered for later.
// (RL10) both status reads are served at once, even during dual.
// (RL11) dual leg values apply to that sequence only; RAM velocities return.
// (RL12) zero, dual and decelerating halt during dual are discarded.
// (RL13) parameter write during dual applies all but the velocities.
// (RL14) signed position range depends on stepping mode and is circular.
// (RL15) move picks the shorter way around the circle.
// (RL16) master uses several moves or run command for the long way.
// (RL17) new same direction move during deceleration accelerates without wait.
// (RL18) end position always reached; rounding cleared back at start velocity.
// (RL19) new velocities and moves are accepted while a motion runs.
// (RL20) master shifts move target left by stepping mode.
// (RL21) safe position disabled when it equals the most negative code.
// (RL22) dual command runs only with undervoltage, pump and step loss clear.
// (RL23) direction from sign of target minus actual at mode width.
// (RL24) buffered commands drain in arrival order after the whole sequence.
`timescale 1ns/100ps
`default_nettype none
`include "dps_consts.svh"
module dps_sequencer
    import dps_pkg::*;
#(
    parameter int BUF_DEPTH = `DPS_BUF_DEPTH
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cmd_valid,
    input  var  dps_cmd_t    cmd,
    input  wire logic [3:0]  ram_vmin,
    input  wire logic [3:0]  ram_vmax,
    input  wire logic [10:0] safe_position,
    input  wire logic [1:0]  step_mode,
    input  wire logic [15:0] actual_position,
    input  wire logic        motion_done,
    input  wire logic        at_vmin,
    input  wire logic        shutdown,
    input  wire logic        undervoltage_flag,
    input  wire logic        pump_fail_flag,
    input  wire logic        steploss_flag,
    output logic             move_valid_q,
    output var  dps_move_t   move_q,
    output logic             dir_pos_q,
    output logic [15:0]      target_position_q,
    output logic             clear_actual_q,
    output logic             referenced_q,
    output logic             halt_now_q,
    output logic             halt_decel_q,
    output logic             zero_position_q,
    output logic             run_q,
    output logic             status_grant_q,
    output logic             param_apply_q,
    output logic             param_vel_apply_q,
    output logic             round_clear_q,
    output logic             dual_active_q
);
    localparam int PW = $clog2(BUF_DEPTH);

    generate
        if (BUF_DEPTH < `DPS_BUF_MIN || BUF_DEPTH > `DPS_BUF_MAX
            || (1 << PW) != BUF_DEPTH)
        begin : g_chk
            $error("BUF_DEPTH must be a power of two from 2 to 16");
        end
    endgenerate

    logic rst_meta_q;
    logic rst_sync_n_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    dps_state_t  state_q;
    dps_state_t  state_d;
    dps_cmd_t    dual_q;
    dps_buf_t    buf_q [BUF_DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0]   cnt_q;
    logic [15:0] target_d;
    logic        mv_vld_d;
    dps_move_t   mv_d;
    logic        ref_d;
    logic        clr_d;
    logic        pop;
    logic        push;
    logic        flush;
    logic        dir_pos;

    // command decoding
    logic op_move, op_safe, op_halt, op_dual, op_status;
    logic op_param, op_decel, op_zero, op_run;
    logic in_dual, flags_clear, safe_en, buf_full, queue_cmd;
    logic [1:0]  shift;
    logic [15:0] cmd_nat;
    logic [15:0] safe_nat;
    logic [15:0] leg_sum;
    dps_buf_t    head;

    assign op_move   = cmd_valid && (cmd.op == DPS_OP_MOVE
                                  || cmd.op == DPS_OP_MOVE_SHORT);
    assign op_safe   = cmd_valid && cmd.op == DPS_OP_GO_SAFE;
    assign op_halt   = cmd_valid && cmd.op == DPS_OP_HALT_NOW;
    assign op_dual   = cmd_valid && cmd.op == DPS_OP_DUAL;
    assign op_status = cmd_valid && (cmd.op == DPS_OP_STATUS1
                                  || cmd.op == DPS_OP_STATUS2);
    assign op_param  = cmd_valid && cmd.op == DPS_OP_PARAM;
    assign op_decel  = cmd_valid && cmd.op == DPS_OP_HALT_DECEL;
    assign op_zero   = cmd_valid && cmd.op == DPS_OP_ZERO_POS;
    assign op_run    = cmd_valid && cmd.op == DPS_OP_RUN;

    assign in_dual     = state_q != DPS_IDLE;
    assign flags_clear = !undervoltage_flag && !pump_fail_flag
                      && !steploss_flag; // RL22
    assign safe_en     = safe_position != `DPS_SAFE_OFF; // RL21
    assign buf_full    = cnt_q == (PW+1)'(BUF_DEPTH);
    assign queue_cmd   = op_move || op_safe; // RL9

    // target words arrive left aligned; work in native steps
    assign shift    = `DPS_MODE_SIXTEENTH - step_mode; // RL20
    assign cmd_nat  = 16'($signed(cmd.pos) >>> shift);
    assign safe_nat = 16'($signed({safe_position, `DPS_SAFE_PAD}) >>> shift);
    assign leg_sum  = dual_q.pos + dual_q.second_leg_offset; // RL2
    assign head     = buf_q[rd_q];

    function automatic dps_move_t mk_move(
        input logic [15:0] t,
        input logic [3:0]  vl,
        input logic [3:0]  vh,
        input logic        rp,
        input logic        rl);
        dps_move_t m;
        m.target   = t;
        m.vmin     = vl;
        m.vmax     = vh;
        m.ramp     = rp;
        m.relative = rl;
        return m;
    endfunction

    always_comb
    begin
        state_d  = state_q;
        target_d = target_position_q;
        mv_vld_d = 1'b0;
        mv_d     = move_q;
        ref_d    = referenced_q;
        clr_d    = 1'b0;
        pop      = 1'b0;
        flush    = 1'b0;
        push     = in_dual && queue_cmd && !buf_full; // RL9
        if (shutdown || op_halt)
        begin
            state_d = DPS_IDLE; // RL6
            flush   = 1'b1;
            push    = 1'b0;
        end
        else
        begin
            case (state_q)
                DPS_IDLE:
                begin
                    if (op_dual && flags_clear) // RL22
                    begin
                        target_d = safe_en ? safe_nat : `DPS_POS_ZERO; // RL8
                        mv_vld_d = 1'b1;
                        mv_d     = mk_move(cmd.pos, cmd.vmin, cmd.vmax,
                                           1'b1, 1'b0); // RL1 RL11
                        state_d  = DPS_LEG1;
                    end
                    else if (op_move) // RL17 RL19
                    begin
                        target_d = cmd_nat;
                        mv_vld_d = 1'b1;
                        mv_d     = mk_move(cmd_nat, ram_vmin, ram_vmax,
                                           1'b1, 1'b0);
                    end
                    else if (op_safe && safe_en)
                    begin
                        target_d = safe_nat;
                        mv_vld_d = 1'b1;
                        mv_d     = mk_move(safe_nat, ram_vmin, ram_vmax,
                                           1'b1, 1'b0);
                    end
                end
                DPS_LEG1:
                begin
                    if (motion_done)
                    begin
                        mv_vld_d = 1'b1;
                        mv_d     = mk_move(leg_sum, dual_q.vmin, dual_q.vmin,
                                           1'b0, 1'b1); // RL2
                        state_d  = DPS_LEG2;
                    end
                end
                DPS_LEG2:
                begin
                    if (motion_done)
                    begin
                        clr_d = 1'b1; // RL3
                        ref_d = 1'b1; // RL5
                        if (safe_en)
                        begin
                            mv_vld_d = 1'b1;
                            mv_d     = mk_move(target_position_q, ram_vmin,
                                               ram_vmax, 1'b1, 1'b0); // RL4 RL11
                            state_d  = DPS_SAFE;
                        end
                        else
                        begin
                            state_d = DPS_DRAIN;
                        end
                    end
                end
                DPS_SAFE:
                begin
                    if (motion_done)
                    begin
                        state_d = DPS_DRAIN;
                    end
                end
                DPS_DRAIN:
                begin
                    if (cnt_q != '0)
                    begin
                        pop = 1'b1; // RL24
                        if (!head.is_safe || safe_en)
                        begin
                            target_d = head.is_safe ? safe_nat : head.pos;
                            mv_vld_d = 1'b1;
                            mv_d     = mk_move(target_d, ram_vmin, ram_vmax,
                                               1'b1, 1'b0);
                        end
                    end
                    else
                    begin
                        state_d = DPS_IDLE;
                    end
                end
                default:
                begin
                    state_d = DPS_IDLE;
                end
            endcase
        end
    end

    dps_short_dir u_dir
    (
        .target    (mv_d.target),
        .actual    (actual_position),
        .step_mode (step_mode),
        .dir_pos   (dir_pos),
        .at_target ()
    );

    always_ff @(posedge clock or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            state_q           <= DPS_IDLE;
            dual_q            <= '0;
            target_position_q <= `DPS_POS_ZERO;
            move_valid_q      <= 1'b0;
            move_q            <= '0;
            dir_pos_q         <= 1'b0;
            referenced_q      <= 1'b0;
            clear_actual_q    <= 1'b0;
        end
        else
        begin
            state_q           <= state_d;
            target_position_q <= target_d;
            move_valid_q      <= mv_vld_d;
            move_q            <= mv_d;
            dir_pos_q         <= dir_pos; // RL15
            referenced_q      <= ref_d;
            clear_actual_q    <= clr_d;
            if (state_q == DPS_IDLE && state_d == DPS_LEG1)
                dual_q <= cmd;
        end
    end

    // pulses for commands carried out by the rest of the controller, plus the round clear and dual active levels
    always_ff @(posedge clock or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            halt_now_q        <= 1'b0;
            halt_decel_q      <= 1'b0;
            zero_position_q   <= 1'b0;
            run_q             <= 1'b0;
            status_grant_q    <= 1'b0;
            param_apply_q     <= 1'b0;
            param_vel_apply_q <= 1'b0;
            round_clear_q     <= 1'b0;
            dual_active_q     <= 1'b0;
        end
        else
        begin
            halt_now_q        <= op_halt; // RL6
            halt_decel_q      <= op_decel && !in_dual; // RL12
            zero_position_q   <= op_zero && !in_dual; // RL12
            run_q             <= op_run && !in_dual && !shutdown;
            status_grant_q    <= op_status; // RL10
            param_apply_q     <= op_param; // RL13
            param_vel_apply_q <= op_param && !in_dual; // RL11 RL13 RL19
            round_clear_q     <= at_vmin; // RL18
            dual_active_q     <= state_d != DPS_IDLE;
        end
    end

    // position buffer, first in first out
    always_ff @(posedge clock or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_q + PW'(push);
            rd_q  <= rd_q + PW'(pop);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop); // RL24
        end
    end

    always_ff @(posedge clock)
    begin
        if (push)
            buf_q[wr_q] <= '{is_safe: op_safe, pos: cmd_nat}; // RL9
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n_q);

    logic start_dual;
    assign start_dual = state_q == DPS_IDLE && op_dual && flags_clear
                     && !shutdown;

    AST_LEG1: assert property (start_dual |=> move_valid_q && move_q.ramp // RL1
        && move_q.target == $past(cmd.pos) && move_q.vmax == $past(cmd.vmax))
        else $error("first leg not issued");
    AST_LEG2: assert property (state_q == DPS_LEG1 && motion_done && !shutdown // RL2
        && !op_halt |=> move_valid_q && !move_q.ramp && move_q.relative
        && move_q.vmax == dual_q.vmin && move_q.target == leg_sum)
        else $error("second leg wrong");
    AST_CLEAR: assert property (state_q == DPS_LEG2 && motion_done && !shutdown // RL3
        && !op_halt |=> clear_actual_q && $stable(target_position_q))
        else $error("actual not cleared");
    AST_SAFE: assert property (state_q == DPS_LEG2 && motion_done && safe_en // RL4
        && !shutdown && !op_halt |=> move_valid_q
        && move_q.target == target_position_q)
        else $error("safe move missing");
    AST_REF: assert property (state_q == DPS_LEG2 && motion_done && !shutdown // RL5
        && !op_halt |=> referenced_q [*2])
        else $error("referenced flag not held");
    AST_ABORT: assert property (in_dual && op_halt |=> state_q == DPS_IDLE // RL6
        && halt_now_q && cnt_q == '0)
        else $error("halt did not abort");
    AST_LOAD: assert property (start_dual && !safe_en // RL8
        |=> target_position_q == `DPS_POS_ZERO)
        else $error("target not zeroed");
    AST_QUEUE: assert property (state_q inside {DPS_LEG1, DPS_LEG2, DPS_SAFE} // RL9
        && queue_cmd && !buf_full && !shutdown && !op_halt
        |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("command not buffered");
    AST_STATUS: assert property (op_status |=> status_grant_q) // RL10
        else $error("status not served");
    AST_DISCARD: assert property (in_dual && (op_zero || op_decel) // RL12
        |=> !zero_position_q && !halt_decel_q)
        else $error("discarded command passed");
    AST_GATE: assert property (state_q == DPS_IDLE && op_dual && !flags_clear // RL22
        |=> state_q == DPS_IDLE && !move_valid_q)
        else $error("dual ran with flags set");

    COV_DUAL_SAFE: cover property (state_q == DPS_SAFE && motion_done);
    COV_DRAIN: cover property (state_q == DPS_DRAIN && pop);
    COV_FULL: cover property (buf_full && in_dual);
endmodule
`default_nettype wire

//--- dps_master_model.sv
// command issuing bus master model facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module dps_master_model
    import dps_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [1:0] step_mode,
    input  wire logic       moving,
    output var  logic       cmd_valid,
    output var  dps_cmd_t   cmd
);
    initial
    begin
        cmd_valid = 1'h0;
        cmd = dps_cmd_t'(0);
    end

    // one word held over one taking edge; a released word shows no stale value
    task automatic send(input dps_op_t op, input logic [15:0] p, input logic [15:0] p2,
                        input logic [3:0] vl, input logic [3:0] vh);
        @(negedge clock);
        cmd_valid = 1'h1;
        cmd = dps_cmd_t'({op, p, p2, vl, vh});
        @(negedge clock);
        cmd_valid = 1'h0;
        cmd = dps_cmd_t'(~cmd);
    endtask

    // target word left aligned by stepping mode; long way is split by the caller
    task automatic move_to(input logic [15:0] native);
        send(DPS_OP_MOVE, native << (2'h3 - step_mode), 16'h0000, 4'h0, 4'h0);
    endtask

    // waits for a running motion to end before the dual command, bounded
    task automatic dual(input logic [15:0] p, input logic [15:0] p2, input logic [3:0] vl, input logic [3:0] vh);
        for (int i = 0; i < 64 && moving === 1'h1; i++) @(negedge clock);
        send(DPS_OP_DUAL, p, p2, vl, vh);
    endtask
endmodule
`default_nettype wire

//--- dps_sequencer_bench.sv
// self-checking bench of the dual position sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, (exp), (got)); end end
module dps_sequencer_bench
    import dps_pkg::*;
;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic        cmd_valid;
    dps_cmd_t    cmd;
    logic [3:0]  ram_vmin = 4'h2;
    logic [3:0]  ram_vmax = 4'hC;
    logic [10:0] safe_position = 11'h010;
    logic [1:0]  step_mode = 2'h3;
    logic [15:0] actual_position = 16'h0000;
    logic        motion_done = 1'h0;
    logic        at_vmin = 1'h0;
    logic        shutdown = 1'h0;
    logic        undervoltage_flag = 1'h0;
    logic        pump_fail_flag = 1'h0;
    logic        steploss_flag = 1'h0;
    logic        move_valid_q, dir_pos_q, clear_actual_q, referenced_q, halt_now_q, halt_decel_q;
    logic        zero_position_q, run_q, status_grant_q, param_apply_q, param_vel_apply_q;
    logic        round_clear_q, dual_active_q;
    dps_move_t   move_q;
    logic [15:0] target_position_q;
    int          err_total = 0;
    int          checks = 0;
    int          moves = 0;

    always #4 clock = ~clock;

    dps_sequencer uut (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .ram_vmin(ram_vmin),
        .ram_vmax(ram_vmax), .safe_position(safe_position), .step_mode(step_mode),
        .actual_position(actual_position), .motion_done(motion_done), .at_vmin(at_vmin),
        .shutdown(shutdown), .undervoltage_flag(undervoltage_flag), .pump_fail_flag(pump_fail_flag),
        .steploss_flag(steploss_flag), .move_valid_q(move_valid_q), .move_q(move_q), .dir_pos_q(dir_pos_q),
        .target_position_q(target_position_q), .clear_actual_q(clear_actual_q), .referenced_q(referenced_q),
        .halt_now_q(halt_now_q), .halt_decel_q(halt_decel_q), .zero_position_q(zero_position_q),
        .run_q(run_q), .status_grant_q(status_grant_q), .param_apply_q(param_apply_q),
        .param_vel_apply_q(param_vel_apply_q), .round_clear_q(round_clear_q), .dual_active_q(dual_active_q)
    );

    dps_master_model mst (
        .clock(clock), .step_mode(step_mode), .moving(dual_active_q), .cmd_valid(cmd_valid), .cmd(cmd)
    );

    always @(posedge clock)
        if (move_valid_q === 1'h1)
            moves++;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic done_pulse();
        @(negedge clock);
        motion_done = 1'h1;
        @(negedge clock);
        motion_done = 1'h0;
    endtask

    task automatic wait_move(input int bound);
        int i = 0;
        do
        begin
            @(negedge clock);
            i++;
        end
        while (i < bound && move_valid_q !== 1'h1);
        `CHK("move issued", 1'h1, move_valid_q)
    endtask

    task automatic wait_idle(input int bound);
        for (int i = 0; i < bound && dual_active_q !== 1'h0; i++) @(negedge clock);
        `CHK("sequence idle", 1'h0, dual_active_q)
    endtask

    // direction table across modes and the wrap point, then moves while moving
    task automatic t_moves();
        logic [1:0]  md [6] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h1};
        logic [15:0] ac [6] = '{16'h0000, 16'h0000, 16'h7530, 16'h0FFF, 16'hF000, 16'h1FFF};
        logic [15:0] tg [6] = '{16'h0064, 16'hFF9C, 16'h8AD0, 16'h0001, 16'h0FFF, 16'hE000};
        logic        dr [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
        dps_op_t     io [4] = '{DPS_OP_ZERO_POS, DPS_OP_HALT_DECEL, DPS_OP_RUN, DPS_OP_PARAM};
        for (int i = 0; i < 6; i++)
        begin
            step_mode = md[i];
            actual_position = ac[i];
            mst.move_to(tg[i]);
            `CHK("move pulse", 1'h1, move_valid_q)
            `CHK("move target", tg[i], target_position_q)
            `CHK("move dir", dr[i], dir_pos_q)
        end
        step_mode = 2'h3;
        actual_position = 16'h0000;
        mst.move_to(16'h0100);
        mst.move_to(16'h0200);
        `CHK("second move", 1'h1, move_valid_q)
        `CHK("second target", 16'h0200, target_position_q)
        done_pulse();
        at_vmin = 1'h1;
        @(negedge clock);
        `CHK("round clear", 1'h1, round_clear_q)
        at_vmin = 1'h0;
        // commands outside a sequence pass straight through
        for (int i = 0; i < 4; i++)
        begin
            mst.send(io[i], 16'h0000, 16'h0000, 4'h5, 4'h6);
            `CHK("idle pulse", 4'h8 >> i, {zero_position_q, halt_decel_q, run_q, param_vel_apply_q})
        end
        $display("test moves done");
    endtask

    // dual with safe position, refused and buffered commands meanwhile
    task automatic t_dual_safe();
        dps_op_t ops [4] = '{DPS_OP_ZERO_POS, DPS_OP_HALT_DECEL, DPS_OP_DUAL, DPS_OP_RUN};
        safe_position = 11'h020;
        actual_position = 16'h0040;
        `CHK("not referenced", 1'h0, referenced_q)
        mst.dual(16'h0200, 16'h0010, 4'h3, 4'h9);
        `CHK("leg one", {1'h1, 16'h0200, 4'h3, 4'h9, 1'h1, 1'h0}, {move_valid_q, move_q})
        `CHK("target preset", 16'h0400, target_position_q)
        for (int i = 0; i < 4; i++)
        begin
            mst.send(ops[i], 16'h0123, 16'h0001, 4'h1, 4'h1);
            `CHK("discarded", 4'h0, {zero_position_q, halt_decel_q, run_q, move_valid_q})
        end
        mst.move_to(16'h0050);
        `CHK("move held", 1'h0, move_valid_q)
        mst.send(DPS_OP_GO_SAFE, 16'h0000, 16'h0000, 4'h0, 4'h0);
        `CHK("safe held", 1'h0, move_valid_q)
        mst.send(DPS_OP_STATUS1, 16'h0000, 16'h0000, 4'h0, 4'h0);
        `CHK("status one", 1'h1, status_grant_q)
        mst.send(DPS_OP_STATUS2, 16'h0000, 16'h0000, 4'h0, 4'h0);
        `CHK("status two", 1'h1, status_grant_q)
        mst.send(DPS_OP_PARAM, 16'h0000, 16'h0000, 4'h5, 4'h6);
        `CHK("param split", 2'h2, {param_apply_q, param_vel_apply_q})
        done_pulse();
        `CHK("leg two", {1'h1, 16'h0210, 4'h3, 4'h3, 1'h0, 1'h1}, {move_valid_q, move_q})
        done_pulse();
        `CHK("actual cleared", 2'h3, {clear_actual_q, referenced_q})
        `CHK("target kept", 16'h0400, target_position_q)
        `CHK("safe move", {1'h1, 16'h0400, 8'h2C}, {move_valid_q, move_q.target, move_q.vmin, move_q.vmax})
        done_pulse();
        wait_move(3);
        `CHK("drain first", 16'h0050, move_q.target)
        wait_move(2);
        `CHK("drain second", 16'h0400, move_q.target)
        wait_idle(4);
        `CHK("still referenced", 1'h1, referenced_q)
        $display("test dual safe done");
    endtask

    // refused dual starts, disabled safe position, halt and shutdown aborts
    task automatic t_dual_abort();
        int m0;
        safe_position = 11'h400;
        mst.send(DPS_OP_GO_SAFE, 16'h0000, 16'h0000, 4'h0, 4'h0);
        `CHK("safe disabled", 1'h0, move_valid_q)
        for (int i = 0; i < 3; i++)
        begin
            {undervoltage_flag, pump_fail_flag, steploss_flag} = 3'h1 << i;
            mst.dual(16'h0100, 16'h0008, 4'h2, 4'h8);
            `CHK("dual refused", 2'h0, {move_valid_q, dual_active_q})
        end
        {undervoltage_flag, pump_fail_flag, steploss_flag} = 3'h0;
        mst.dual(16'h0100, 16'h0008, 4'h2, 4'h8);
        `CHK("target zero", {1'h1, 16'h0000}, {dual_active_q, target_position_q})
        mst.move_to(16'h0070);
        mst.send(DPS_OP_HALT_NOW, 16'h0000, 16'h0000, 4'h0, 4'h0);
        `CHK("halt now", 1'h1, halt_now_q)
        m0 = moves;
        wait_idle(3);
        repeat (6) @(negedge clock);
        `CHK("buffer flushed", m0, moves)
        mst.dual(16'h0100, 16'h0008, 4'h2, 4'h8);
        shutdown = 1'h1;
        @(negedge clock);
        wait_idle(3);
        shutdown = 1'h0;
        $display("test dual abort done");
    endtask

    initial
    begin
        #(8 * 20000);
        err_total++;
        $display("watchdog expired");
        stop_test();
    end

    initial
    begin
        repeat (16) @(negedge clock);
        rst_n = 1'h1;
        repeat (4) @(negedge clock);
        t_moves();
        t_dual_safe();
        t_dual_abort();
        stop_test();
    end
endmodule
`default_nettype wire
